// file: ssc_pkg.sv
// package for the sequence step configuration block
// assumes a 32-bit ahb-lite slave wrapper around two 16-bit step registers
package ssc_pkg;
    // ====================================================================
    // register map
    localparam logic [7:0]  STEP_CFG_INDEX      = 8'h9e;  // this step
    localparam logic [7:0]  NEXT_STEP_CFG_INDEX = 8'h9f;  // following step
    localparam logic [7:0]  SEQ_CTRL_INDEX      = 8'ha8;  // sequencer control
    localparam logic [7:0]  SEQ_STAT_INDEX      = 8'ha9;  // sequencer status
    // ====================================================================
    // reset values
    localparam logic [15:0] STEP_CFG_RESET      = 16'h000e;
    localparam logic [15:0] NEXT_STEP_CFG_RESET = 16'h000f;
    // ====================================================================
    // field positions
    localparam int STEP_EN_BIT   = 15;
    localparam int GAIN_HI       = 14;
    localparam int GAIN_LO       = 13;
    localparam int NEG_SEL_BIT   = 4;
    localparam int POS_SEL_HI    = 3;
    localparam logic [15:0] STEP_WRITE_MASK = 16'he01f;  // 12:5 reserved
    // ====================================================================
    // timing: conversion dwell per step, 2 us at 50 MHz
    localparam int CLK_PERIOD_NS   = 20;
    localparam int CONV_TIME_NS    = 2000;
    localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // ====================================================================
    // gain codes seen by the converter
    typedef enum logic [1:0] {
        SSC_GAIN_1,
        SSC_GAIN_2,
        SSC_GAIN_4
    } ssc_gain_e;
    // negative input code: 0 ground, 1 input seven, 2 automatic
    localparam logic [1:0] NEG_GROUND = 2'h0;
    localparam logic [1:0] NEG_IN7    = 2'h1;
    localparam logic [1:0] NEG_AUTO   = 2'h2;
endpackage

// file: ssc_step_if.sv
// interface carrying one decoded step setting between modules
// assumes one producer (step decoder) and one consumer (top)
`timescale 1ns/10ps
interface ssc_step_if;
    logic        enable;     // step included in sequence
    logic [1:0]  gain;       // decoded gain code
    logic [1:0]  neg_sel;    // decoded negative input
    logic [3:0]  pos_sel;    // positive input code
    modport producer (output enable, gain, neg_sel, pos_sel);
    modport consumer (input enable, gain, neg_sel, pos_sel);
endinterface

// file: ssc_step_decode.sv
// decoder turning one raw step register into converter settings
// assumes the raw word comes from flip-flops on the same clock
`timescale 1ns/10ps
module ssc_step_decode (
    // raw register
    input  wire logic [15:0] i_cfg,
    // decoded settings
    ssc_step_if.producer     step
);
    // ====================================================================
    // field decode
    wire logic [1:0] raw_gain = i_cfg[ssc_pkg::GAIN_HI:ssc_pkg::GAIN_LO];
    wire logic [3:0] pos_code = i_cfg[ssc_pkg::POS_SEL_HI:0];
    // internal sources live in the upper half of the code space
    wire logic       internal = pos_code[3];
    assign step.enable  = i_cfg[ssc_pkg::STEP_EN_BIT];
    // both upper codes give gain 4
    assign step.gain    = (raw_gain == 2'h0) ? 2'(ssc_pkg::SSC_GAIN_1) :
                          (raw_gain == 2'h1) ? 2'(ssc_pkg::SSC_GAIN_2) :
                          2'(ssc_pkg::SSC_GAIN_4);
    // negative bit is ignored once an internal source is chosen
    assign step.neg_sel = internal ? ssc_pkg::NEG_AUTO :
                          (i_cfg[ssc_pkg::NEG_SEL_BIT] ?
                           ssc_pkg::NEG_IN7 : ssc_pkg::NEG_GROUND);
    // codes 0..7 external inputs, 8..15 internal sources in order
    assign step.pos_sel = pos_code;
endmodule

// file: ssc_dwell_timer.sv
// conversion dwell counter: pulses done after a fixed number of cycles
// assumes start is a one-cycle pulse from the same clock
`timescale 1ns/10ps
module ssc_dwell_timer (
    // clock, reset, enable
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_clk_en,
    // control
    input  wire logic i_start,
    output logic      o_done
);
    localparam int W = $clog2(ssc_pkg::CONV_CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(ssc_pkg::CONV_CYCLES - 1);
    logic [W-1:0] count;   // cycles spent in this step
    logic         busy;    // dwell running
    wire  logic   at_end = busy && (count == LAST);
    // ====================================================================
    // counter
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count  <= '0;
            busy   <= 1'b0;
            o_done <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= at_end;
            if (i_start) begin
                busy  <= 1'b1;
                count <= '0;
            end else if (at_end) begin
                busy  <= 1'b0;
            end else if (busy) begin
                count <= count + W'(1);
            end
        end
    end
endmodule

// file: ssc_top.sv
// top of the step configuration block: ahb-lite slave, two step
// registers, and a small sequencer walking them.
// assumes a single ahb-lite master; hreadyout is the bus hready.
`timescale 1ns/10ps
module ssc_top (
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_clk_en,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // converter settings for the step being converted
    output logic             o_conv_active,
    output logic             o_conv_step,
    output logic [1:0]       o_conv_gain,
    output logic [1:0]       o_conv_neg_sel,
    output logic [3:0]       o_conv_pos_sel
);
    // ====================================================================
    // byte addresses of the registers
    localparam logic [31:0] ADDR_STEP = {22'h0, ssc_pkg::STEP_CFG_INDEX,
                                         2'h0};
    localparam logic [31:0] ADDR_NEXT = {22'h0,
                                         ssc_pkg::NEXT_STEP_CFG_INDEX, 2'h0};
    localparam logic [31:0] ADDR_CTRL = {22'h0, ssc_pkg::SEQ_CTRL_INDEX,
                                         2'h0};
    localparam logic [31:0] ADDR_STAT = {22'h0, ssc_pkg::SEQ_STAT_INDEX,
                                         2'h0};

    // ====================================================================
    // storage
    logic [15:0] step_cfg [2];    // index 0 this step, 1 next step
    logic        seq_run;         // software run control
    logic        wr_pend;         // write data phase pending
    logic [31:0] wr_addr;         // address latched in address phase
    logic        step_idx;        // step now being converted
    logic [7:0]  conv_count;      // completed conversions, wraps

    // reset value by index, used twice
    function automatic logic [15:0] reset_of(input logic idx);
        reset_of = idx ? ssc_pkg::NEXT_STEP_CFG_RESET
                       : ssc_pkg::STEP_CFG_RESET;
    endfunction

    // register index from byte address; 2'h3 means not a step register
    function automatic logic [1:0] step_index(input logic [31:0] a);
        step_index = (a == ADDR_STEP) ? 2'h0 :
                     (a == ADDR_NEXT) ? 2'h1 : 2'h3;
    endfunction

    // ====================================================================
    // bus decode
    wire logic addr_phase = i_hsel && i_hready && i_htrans[1];
    wire logic [1:0] wr_idx = step_index(wr_addr);
    wire logic [1:0] rd_idx = step_index(i_haddr);
    // reserved bits are masked on write so they always read back zero
    wire logic [15:0] wr_val = i_hwdata[15:0]
                               & ssc_pkg::STEP_WRITE_MASK;
    wire logic [31:0] stat_word = {23'h0, step_idx, conv_count};
    wire logic [31:0] rd_word =
        (rd_idx != 2'h3)       ? {16'h0, step_cfg[rd_idx[0]]} :
        (i_haddr == ADDR_CTRL) ? {31'h0, seq_run} :
        (i_haddr == ADDR_STAT) ? stat_word : 32'h0;

    // ====================================================================
    // decoded settings of each step
    ssc_step_if dec [2] ();
    logic [1:0]  dec_en;
    logic [1:0]  dec_gain [2];
    logic [1:0]  dec_neg  [2];
    logic [3:0]  dec_pos  [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_step
            ssc_step_decode u_dec (
                .i_cfg (step_cfg[g]),
                .step  (dec[g])
            );
            assign dec_en[g]   = dec[g].enable;
            assign dec_gain[g] = dec[g].gain;
            assign dec_neg[g]  = dec[g].neg_sel;
            assign dec_pos[g]  = dec[g].pos_sel;

            // step register: write in the data phase, reserved bits zero
            always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    step_cfg[g] <= reset_of(1'(g));
                end else if (i_clk_en && wr_pend
                             && wr_idx == 2'(g)) begin
                    step_cfg[g] <= wr_val;
                end
            end
        end
    endgenerate

    // ====================================================================
    // bus slave: zero wait states, always okay
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_pend     <= 1'b0;
            wr_addr     <= 32'h0;
            o_hrdata    <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else if (i_clk_en) begin
            // a write's data arrives one cycle after its address
            wr_pend <= addr_phase && i_hwrite;
            if (addr_phase) begin
                wr_addr <= i_haddr;
            end
            // read data registered so it stands in the data phase
            if (addr_phase && !i_hwrite) begin
                o_hrdata <= rd_word;
            end
        end
    end

    // ====================================================================
    // run control register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seq_run <= 1'b0;
        end else if (i_clk_en && wr_pend && wr_addr == ADDR_CTRL) begin
            seq_run <= i_hwdata[0];
        end
    end

    // ====================================================================
    // sequencer
    typedef enum logic [1:0] {
        SSC_IDLE,
        SSC_PICK,
        SSC_CONV
    } ssc_state_e;
    ssc_state_e state;
    ssc_state_e next_state;
    logic       dwell_done;
    logic       start_conv;

    // a disabled step is skipped without spending a conversion on it
    wire logic  cur_enabled = dec_en[step_idx];
    wire logic  any_enabled = |dec_en;

    always_comb begin
        next_state = state;
        start_conv = 1'b0;
        case (state)
            SSC_IDLE: begin
                if (seq_run && any_enabled) begin
                    next_state = SSC_PICK;
                end
            end
            SSC_PICK: begin
                if (!seq_run || !any_enabled) begin
                    next_state = SSC_IDLE;
                end else if (cur_enabled) begin
                    start_conv = 1'b1;
                    next_state = SSC_CONV;
                end
            end
            SSC_CONV: begin
                if (dwell_done) begin
                    next_state = SSC_PICK;
                end
            end
            default: next_state = SSC_IDLE;
        endcase
    end

    ssc_dwell_timer u_dwell (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_start   (start_conv),
        .o_done    (dwell_done)
    );

    // state, step pointer and counter
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state      <= SSC_IDLE;
            step_idx   <= 1'b0;
            conv_count <= 8'h00;
        end else if (i_clk_en) begin
            state <= next_state;
            // advance past disabled steps, and after each conversion
            if ((state == SSC_PICK && !cur_enabled)
                || (state == SSC_CONV && dwell_done)) begin
                step_idx <= ~step_idx;
            end
            if (state == SSC_CONV && dwell_done) begin
                conv_count <= conv_count + 8'h01;
            end
        end
    end

    // ====================================================================
    // converter outputs, held for the whole conversion of a step
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_conv_active  <= 1'b0;
            o_conv_step    <= 1'b0;
            o_conv_gain    <= 2'h0;
            o_conv_neg_sel <= 2'h0;
            o_conv_pos_sel <= 4'h0;
        end else if (i_clk_en) begin
            o_conv_active <= (next_state == SSC_CONV);
            if (start_conv) begin
                // each conversion uses its own step's selections
                o_conv_step    <= step_idx;
                o_conv_gain    <= dec_gain[step_idx];
                o_conv_neg_sel <= dec_neg[step_idx];
                o_conv_pos_sel <= dec_pos[step_idx];
            end
        end
    end
endmodule

// file: ssc_top_chk.sv
// checker for the step configuration block: bus and converter outputs
// assumes it is bound to ssc_top and sees only that module's ports
`timescale 1ns/10ps
module ssc_top_chk (
    // clock, reset, enable
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic        i_clk_en,
    // ahb-lite slave
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // converter settings
    input wire logic        o_conv_active,
    input wire logic        o_conv_step,
    input wire logic [1:0]  o_conv_gain,
    input wire logic [1:0]  o_conv_neg_sel,
    input wire logic [3:0]  o_conv_pos_sel
);
    // ======================================================================
    // decode of read address phases taken by the slave
    wire rd_any  = i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_clk_en;
    wire rd_step = rd_any && (i_haddr == 32'h278 || i_haddr == 32'h27c);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // ======================================================================
    // assertions
    a_bus_ready_okay: assert property (o_hreadyout && !o_hresp)
        else $error("slave stalled or answered with an error");
    a_rsvd_read_zero: assert property (rd_step |=>
        o_hrdata[31:16] == 16'h0000 && o_hrdata[12:5] == 8'h00)
        else $error("reserved step bits read nonzero");
    a_read_data_stands: assert property (!rd_any |=> $stable(o_hrdata))
        else $error("read data changed without a read");
    a_gain_code_folded: assert property (
        o_conv_active |-> o_conv_gain != 2'h3)
        else $error("illegal gain code on converter");
    a_auto_negative: assert property (
        o_conv_active && o_conv_pos_sel[3] |-> o_conv_neg_sel == 2'h2)
        else $error("internal source without automatic negative");
    a_ext_negative: assert property (
        o_conv_active && !o_conv_pos_sel[3] |-> o_conv_neg_sel != 2'h2)
        else $error("external source with automatic negative");
    a_settings_stable: assert property (
        o_conv_active && $past(o_conv_active) |->
        $stable({o_conv_step, o_conv_gain, o_conv_neg_sel, o_conv_pos_sel}))
        else $error("settings moved during a conversion");
    a_dwell_minimum: assert property (
        $rose(o_conv_active) |-> o_conv_active[*8])
        else $error("conversion cut short");
endmodule

bind ssc_top ssc_top_chk ssc_top_chk_inst (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_conv_active(o_conv_active), .o_conv_step(o_conv_step),
    .o_conv_gain(o_conv_gain), .o_conv_neg_sel(o_conv_neg_sel),
    .o_conv_pos_sel(o_conv_pos_sel));

// file: adc_sequence_step_config_bench.sv
// self-checking bench for the step configuration block
// assumes ssc_top answers ahb-lite with no wait states; checker is bound
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module adc_sequence_step_config_bench;
    // ======================================================================
    // stimulus and observed signals
    logic        i_sys_clk = 1'b0;    // 50 mhz system clock
    logic        i_reset_n = 1'b0;    // async reset, low active
    logic        i_clk_en  = 1'b1;    // clock enable, low freezes the block
    logic        i_hsel    = 1'b0;    // slave select
    logic [31:0] i_haddr   = 32'h0;   // byte address
    logic [1:0]  i_htrans  = 2'h0;    // idle or nonseq
    logic        i_hwrite  = 1'b0;    // write strobe
    logic [31:0] i_hwdata  = 32'h0;   // write data
    logic [31:0] o_hrdata;            // read data
    logic        o_hreadyout;         // slave ready, fed back as hready
    logic        o_hresp;             // response
    logic        o_conv_active;       // conversion running
    logic        o_conv_step;         // step being converted
    logic [1:0]  o_conv_gain;         // decoded gain
    logic [1:0]  o_conv_neg_sel;      // decoded negative input
    logic [3:0]  o_conv_pos_sel;      // positive code
    int          err_total = 0;       // mismatches
    int          compares  = 0;       // comparisons made
    logic [31:0] rd;                  // last read word
    logic        s_a;                 // step of first conversion seen
    ssc_top ssc_top_inst (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
        .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_conv_active(o_conv_active), .o_conv_step(o_conv_step),
        .o_conv_gain(o_conv_gain), .o_conv_neg_sel(o_conv_neg_sel),
        .o_conv_pos_sel(o_conv_pos_sel));
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // ======================================================================
    // closing report, also reached when a wait runs out
    task automatic complete_run;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // bounded wait for an edge at which hready is high
    task automatic ready_edge;
        int n;
        n = 0;
        @(posedge i_sys_clk);
        while (o_hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                complete_run();
            end
            @(posedge i_sys_clk);
        end
    endtask
    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, d);
        @(posedge i_sys_clk);
        i_hsel   <= 1'b1;
        i_haddr  <= a;
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        ready_edge();
        i_hsel   <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        ready_edge();
        rd = o_hrdata;
    endtask
    // bounded wait for the conversion flag to reach a level
    task automatic conv_at(input logic lvl);
        int n;
        // step off the edge so the flag is looked at once it has settled
        #1;
        for (n = 0; o_conv_active !== lvl; n++) begin
            if (n > 500) begin
                err_total++;
                complete_run();
            end
            @(posedge i_sys_clk);
            #1;
        end
    endtask
    // ======================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        // reset values and an unmapped place
        ahb(1'b0, 32'h278, 32'h0); `CHK(rd, 32'h0000000e)
        ahb(1'b0, 32'h27c, 32'h0); `CHK(rd, 32'h0000000f)
        ahb(1'b0, 32'h300, 32'h0); `CHK(rd, 32'h00000000)
        $display("test reset values done");
        // reserved and upper bits ignore writes
        ahb(1'b1, 32'h278, 32'hffffffff);
        ahb(1'b0, 32'h278, 32'h0); `CHK(rd, 32'h0000e01f)
        $display("test reserved bits done");
        // every positive code, gains and negative bit varied
        ahb(1'b1, 32'h2a0, 32'h1);
        for (int i = 0; i < 16; i++) begin
            ahb(1'b1, 32'h278, {16'h0, 1'b1, i[1:0], 8'h0, i[0], i[3:0]});
            conv_at(1'b1);
            conv_at(1'b0);
            conv_at(1'b1);
            `CHK(o_conv_step, 1'b0)
            `CHK(o_conv_pos_sel, i[3:0])
            `CHK(o_conv_gain, i[1] ? 2'h2 : i[1:0])
            `CHK(o_conv_neg_sel, i[3] ? 2'h2 : {1'b0, i[0]})
        end
        $display("test input codes done");
        // second step enabled: steps alternate with their own settings
        ahb(1'b1, 32'h27c, 32'h0000a01a);
        conv_at(1'b0);
        conv_at(1'b1);
        s_a = o_conv_step;
        conv_at(1'b0);
        conv_at(1'b1);
        `CHK(o_conv_step, ~s_a)
        `CHK(o_conv_pos_sel, o_conv_step ? 4'ha : 4'hf)
        `CHK(o_conv_gain, o_conv_step ? 2'h1 : 2'h2)
        $display("test alternation done");
        // frozen clock enable: a conversion outlasts its own dwell
        conv_at(1'b1);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        repeat (150) @(posedge i_sys_clk);
        #1;
        `CHK(o_conv_active, 1'b1)
        @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        $display("test clock enable done");
        // reset in mid-run: conversion flag and both registers back to reset
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        #1;
        `CHK(o_conv_active, 1'b0)
        ahb(1'b0, 32'h278, 32'h0); `CHK(rd, 32'h0000000e)
        ahb(1'b0, 32'h27c, 32'h0); `CHK(rd, 32'h0000000f)
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
